// *** include/fifo_flag_pkg.sv ***
// Shared constants and types for the FIFO status flag block.
// Assumes a single 32-bit Avalon-MM slave port with byte addresses.

package fifo_flag_pkg;

  // ---------------------------------------------------------------
  // Word counts
  // ---------------------------------------------------------------
  localparam int COUNT_W = 13;
  localparam logic [12:0] DEPTH_X18 = 13'h0800;
  localparam logic [12:0] DEPTH_X9 = 13'h1000;
  localparam logic [12:0] OFFSET_RESET = 13'h007F;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_AE_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_AF_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h14;
  localparam logic [7:0] ADDR_INT_MASK = 8'h18;

  // Control register: bit 0 fall-through, bit 1 input x18, bit 2 output x18
  localparam int CTRL_W = 3;
  localparam logic [2:0] CTRL_RESET = 3'h6;

  // Interrupt status and mask bit positions
  localparam int INT_W = 7;
  localparam int INT_EMPTY = 0;
  localparam int INT_ALMOST_EMPTY = 1;
  localparam int INT_HALF_FULL = 2;
  localparam int INT_ALMOST_FULL = 3;
  localparam int INT_FULL = 4;
  localparam int INT_OVERFLOW = 5;
  localparam int INT_UNDERFLOW = 6;
  localparam logic [6:0] INT_RESET = 7'h00;

  // Bus reset values
  localparam logic [31:0] READDATA_RESET = 32'h00000000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic out_x18;
    logic in_x18;
    logic first_word_fall_through;
  } ctrl_type;

  // Each field is true while that condition holds
  typedef struct packed {
    logic full;
    logic almost_full;
    logic half_full;
    logic almost_empty;
    logic empty;
  } flag_set_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_type;

endpackage

// *** rtl/level_sync.sv ***
// Two-stage synchroniser for slow levels such as configuration straps.
// Assumes the input changes far slower than the clock; no reset so it
// tracks the pin while the block is held in reset.

`timescale 1ns/100ps

module level_sync (
  input wire logic clk,
  input wire logic din,
  output logic dout
);

  logic meta;
  logic next_meta;
  logic next_dout;

  always_comb begin
    next_meta = din;
    next_dout = meta;
  end

  always_ff @(posedge clk) begin
    meta <= next_meta;
    dout <= next_dout;
  end

endmodule

// *** rtl/fifo_status_flags.sv ***
// Status flag generator of a FIFO: word count, threshold flags,
// Avalon-MM register slave and one level interrupt.
// Assumes writer and reader logic run on clk_sys and mark their own clock
// edges with one-cycle tick inputs; only the timing strap is asynchronous.
//
// Function
// - Timing mode strap latched during master reset
// - Synchronous almost-full changes on write edges only
// - Synchronous almost-empty changes on read edges only
// - Strap low selects asynchronous flag timing
// - Async almost-full: write sets, read clears
// - Async almost-empty: read sets, write clears
// - Standard mode thresholds from depth and offsets
// - Fall-through thresholds shifted by one word
// - Fall-through count includes output register
// - Offsets n, m held in registers
//
// The register addresses and register access over Avalon-MM are this design's own decisions.

`timescale 1ns/100ps

module fifo_status_flags (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic flag_timing_select,
  input wire logic write_clock_tick,
  input wire logic read_clock_tick,
  input wire logic write_enable,
  input wire logic read_enable,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic empty_flag_n,
  output logic almost_empty_flag_n,
  output logic half_full_flag_n,
  output logic almost_full_flag_n,
  output logic full_flag_n
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic fifo_flag_pkg::flag_set_type flag_levels(
    input logic [12:0] words,
    input logic [12:0] depth,
    input logic [12:0] n,
    input logic [12:0] m,
    input logic first_word_fall_through
  );
    fifo_flag_pkg::flag_set_type lv;
    logic [13:0] w;
    logic [13:0] ex;
    w = {1'b0, words};
    ex = {13'h0000, first_word_fall_through};
    lv.empty = (w == 14'h0000);
    lv.almost_empty = (w <= ({1'b0, n} + ex));
    lv.half_full = (w > ({2'h0, depth[12:1]} + ex));
    // Written as a sum so that no difference can wrap below zero
    lv.almost_full = ((w + {1'b0, m}) >= ({1'b0, depth} + ex));
    lv.full = (w == ({1'b0, depth} + ex));
    return lv;
  endfunction

  function automatic logic [12:0] merge_offset(
    input logic [12:0] old,
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    logic [12:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      r[12:8] = wdata[12:8];
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Reset release and timing strap
  // ---------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic reset_n;
  logic strap_sync;
  logic sync_timing;
  logic next_sync_timing;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign reset_n = rst_pipe[1];

  level_sync u_strap_sync (
    .clk(clk_sys),
    .din(flag_timing_select),
    .dout(strap_sync)
  );

  // Tracks the strap only while reset is held, then freezes until the next reset
  always_comb begin
    next_sync_timing = reset_n ? sync_timing : strap_sync;
  end

  always_ff @(posedge clk_sys) begin
    sync_timing <= next_sync_timing;
  end

  // ---------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------
  fifo_flag_pkg::bus_state_type bus_state;
  fifo_flag_pkg::bus_state_type next_bus_state;
  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic write_commit;
  logic [31:0] read_word;

  fifo_flag_pkg::ctrl_type ctrl;
  fifo_flag_pkg::ctrl_type next_ctrl;
  logic [12:0] ae_offset;
  logic [12:0] next_ae_offset;
  logic [12:0] af_offset;
  logic [12:0] next_af_offset;
  logic [6:0] int_status;
  logic [6:0] next_int_status;
  logic [6:0] int_mask;
  logic [6:0] next_int_mask;
  logic next_irq;
  logic [12:0] count;
  logic [12:0] next_count;
  logic depth_x9;

  always_comb begin
    read_word = 32'h00000000;
    case (avs_address)
      fifo_flag_pkg::ADDR_CTRL: begin
        read_word = {29'h00000000, ctrl};
      end
      fifo_flag_pkg::ADDR_AE_OFFSET: begin
        read_word = {19'h00000, ae_offset};
      end
      fifo_flag_pkg::ADDR_AF_OFFSET: begin
        read_word = {19'h00000, af_offset};
      end
      fifo_flag_pkg::ADDR_FLAGS: begin
        read_word = {25'h0000000, depth_x9, sync_timing, full_flag_n, almost_full_flag_n,
                     half_full_flag_n, almost_empty_flag_n, empty_flag_n};
      end
      fifo_flag_pkg::ADDR_COUNT: begin
        read_word = {19'h00000, count};
      end
      fifo_flag_pkg::ADDR_INT_STATUS: begin
        read_word = {25'h0000000, int_status};
      end
      fifo_flag_pkg::ADDR_INT_MASK: begin
        read_word = {25'h0000000, int_mask};
      end
      default: begin
        read_word = 32'h00000000;
      end
    endcase
  end

  // Every access answers one cycle after it is seen; writes land one edge later, at the end of the answer cycle
  always_comb begin
    next_bus_state = bus_state;
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    case (bus_state)
      fifo_flag_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_bus_state = fifo_flag_pkg::BUS_ACK;
          next_waitrequest = 1'b0;
          if (avs_read) begin
            next_readdata = read_word;
          end
        end
      end
      fifo_flag_pkg::BUS_ACK: begin
        next_bus_state = fifo_flag_pkg::BUS_IDLE;
      end
      default: begin
        next_bus_state = fifo_flag_pkg::BUS_IDLE;
      end
    endcase
  end

  assign write_commit = (bus_state == fifo_flag_pkg::BUS_ACK) && avs_write;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus_state <= fifo_flag_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= fifo_flag_pkg::READDATA_RESET;
    end else begin
      bus_state <= next_bus_state;
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_ae_offset = ae_offset;
    next_af_offset = af_offset;
    next_int_mask = int_mask;
    if (write_commit) begin
      case (avs_address)
        fifo_flag_pkg::ADDR_CTRL: begin
          if (avs_byteenable[0]) begin
            next_ctrl = avs_writedata[2:0];
          end
        end
        fifo_flag_pkg::ADDR_AE_OFFSET: begin
          next_ae_offset = merge_offset(ae_offset, avs_writedata, avs_byteenable);
        end
        fifo_flag_pkg::ADDR_AF_OFFSET: begin
          next_af_offset = merge_offset(af_offset, avs_writedata, avs_byteenable);
        end
        fifo_flag_pkg::ADDR_INT_MASK: begin
          if (avs_byteenable[0]) begin
            next_int_mask = avs_writedata[6:0];
          end
        end
        default: begin
          next_ctrl = ctrl;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= fifo_flag_pkg::CTRL_RESET;
      ae_offset <= fifo_flag_pkg::OFFSET_RESET;
      af_offset <= fifo_flag_pkg::OFFSET_RESET;
      int_mask <= fifo_flag_pkg::INT_RESET;
    end else begin
      ctrl <= next_ctrl;
      ae_offset <= next_ae_offset;
      af_offset <= next_af_offset;
      int_mask <= next_int_mask;
    end
  end

  // ---------------------------------------------------------------
  // Word count and flags
  // ---------------------------------------------------------------
  logic [12:0] depth;
  logic [12:0] capacity;
  logic do_write;
  logic do_read;
  logic write_blocked;
  logic read_blocked;
  fifo_flag_pkg::flag_set_type lv;
  logic next_empty_n;
  logic next_ae_n;
  logic next_hf_n;
  logic next_af_n;
  logic next_full_n;

  always_comb begin
    depth_x9 = !ctrl.in_x18 && !ctrl.out_x18;
    depth = depth_x9 ? fifo_flag_pkg::DEPTH_X9 : fifo_flag_pkg::DEPTH_X18;
    capacity = depth + {12'h000, ctrl.first_word_fall_through};
    write_blocked = write_clock_tick && write_enable && (count == capacity);
    read_blocked = read_clock_tick && read_enable && (count == 13'h0000);
    do_write = write_clock_tick && write_enable && !write_blocked;
    do_read = read_clock_tick && read_enable && !read_blocked;
    next_count = count;
    if (do_write && !do_read) begin
      next_count = count + 13'h0001;
    end else if (do_read && !do_write) begin
      next_count = count - 13'h0001;
    end
    lv = flag_levels(next_count, depth, ae_offset, af_offset, ctrl.first_word_fall_through);
    // In fall-through mode these pins carry output-ready and input-ready
    next_empty_n = ctrl.first_word_fall_through ? lv.empty : !lv.empty;
    next_full_n = ctrl.first_word_fall_through ? lv.full : !lv.full;
    next_hf_n = !lv.half_full;
    next_af_n = almost_full_flag_n;
    next_ae_n = almost_empty_flag_n;
    if (sync_timing) begin
      if (write_clock_tick) begin
        next_af_n = !lv.almost_full;
      end
      if (read_clock_tick) begin
        next_ae_n = !lv.almost_empty;
      end
    end else begin
      if (write_clock_tick && lv.almost_full) begin
        next_af_n = 1'b0;
      end else if (read_clock_tick && !lv.almost_full) begin
        next_af_n = 1'b1;
      end
      if (read_clock_tick && lv.almost_empty) begin
        next_ae_n = 1'b0;
      end else if (write_clock_tick && !lv.almost_empty) begin
        next_ae_n = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count <= 13'h0000;
      empty_flag_n <= 1'b0;
      almost_empty_flag_n <= 1'b0;
      half_full_flag_n <= 1'b1;
      almost_full_flag_n <= 1'b1;
      full_flag_n <= 1'b1;
    end else begin
      count <= next_count;
      empty_flag_n <= next_empty_n;
      almost_empty_flag_n <= next_ae_n;
      half_full_flag_n <= next_hf_n;
      almost_full_flag_n <= next_af_n;
      full_flag_n <= next_full_n;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  logic [6:0] int_event;
  logic [6:0] int_clear;

  always_comb begin
    int_event = 7'h00;
    int_event[fifo_flag_pkg::INT_EMPTY] = do_read && lv.empty;
    int_event[fifo_flag_pkg::INT_ALMOST_EMPTY] = almost_empty_flag_n && !next_ae_n;
    int_event[fifo_flag_pkg::INT_HALF_FULL] = half_full_flag_n && !next_hf_n;
    int_event[fifo_flag_pkg::INT_ALMOST_FULL] = almost_full_flag_n && !next_af_n;
    int_event[fifo_flag_pkg::INT_FULL] = do_write && lv.full;
    int_event[fifo_flag_pkg::INT_OVERFLOW] = write_blocked;
    int_event[fifo_flag_pkg::INT_UNDERFLOW] = read_blocked;
    int_clear = 7'h00;
    if (write_commit && (avs_address == fifo_flag_pkg::ADDR_INT_STATUS) && avs_byteenable[0]) begin
      int_clear = avs_writedata[6:0];
    end
    // A new event in the clearing cycle survives the clear
    next_int_status = (int_status & ~int_clear) | int_event;
    next_irq = |(next_int_status & next_int_mask);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      int_status <= fifo_flag_pkg::INT_RESET;
      irq <= 1'b0;
    end else begin
      int_status <= next_int_status;
      irq <= next_irq;
    end
  end

endmodule

// *** verif/fifo_status_flags_asserts.sv ***
// Concurrent checks on the ports of the FIFO status flag block.
// Assumes the strap stays steady while rstn is held low.
`timescale 1ns/100ps
module fifo_status_flags_asserts (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic flag_timing_select,
  input wire logic write_clock_tick,
  input wire logic read_clock_tick,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic almost_empty_flag_n,
  input wire logic almost_full_flag_n
);
  logic sync_mode;
  logic next_sync_mode;

  // Own copy of the timing mode, taken only while reset is held
  always_comb begin
    next_sync_mode = rstn ? sync_mode : flag_timing_select;
  end
  always_ff @(posedge clk_sys) begin
    sync_mode <= next_sync_mode;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_bus_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_has_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  a_af_sync_wclk: assert property (
    sync_mode && $changed(almost_full_flag_n) |-> $past(write_clock_tick))
    else $error("sync almost-full moved without a write edge");
  a_ae_sync_rclk: assert property (
    sync_mode && $changed(almost_empty_flag_n) |-> $past(read_clock_tick))
    else $error("sync almost-empty moved without a read edge");
  a_af_async_fall: assert property (
    !sync_mode && $fell(almost_full_flag_n) |-> $past(write_clock_tick))
    else $error("async almost-full fell without a write edge");
  a_af_async_rise: assert property (
    !sync_mode && $rose(almost_full_flag_n) |-> $past(read_clock_tick))
    else $error("async almost-full rose without a read edge");
  a_ae_async_fall: assert property (
    !sync_mode && $fell(almost_empty_flag_n) |-> $past(read_clock_tick))
    else $error("async almost-empty fell without a read edge");
  a_ae_async_rise: assert property (
    !sync_mode && $rose(almost_empty_flag_n) |-> $past(write_clock_tick))
    else $error("async almost-empty rose without a write edge");
endmodule

bind fifo_status_flags fifo_status_flags_asserts checker_inst (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .flag_timing_select(flag_timing_select),
  .write_clock_tick(write_clock_tick),
  .read_clock_tick(read_clock_tick),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .almost_empty_flag_n(almost_empty_flag_n),
  .almost_full_flag_n(almost_full_flag_n)
);

// *** verif/fifo_port_model.sv ***
// Writer and reader logic at the far side of the flag block.
// Assumes the bench asks for at most one edge of each clock per cycle.
`timescale 1ns/100ps
module fifo_port_model (
  input wire logic want_write,
  input wire logic want_read,
  output logic write_clock_tick,
  output logic write_enable,
  output logic read_clock_tick,
  output logic read_enable
);
  // Edges only when asked, so both clocks stand still between requests
  assign write_clock_tick = want_write;
  assign write_enable = want_write;
  assign read_clock_tick = want_read;
  assign read_enable = want_read;
endmodule

// *** verif/fifo_status_flag_logic_tb.sv ***
// Self-checking bench for the FIFO status flag block.
// Assumes one clk_sys domain; the port model makes the clock ticks.
`timescale 1ns/100ps
module fifo_status_flag_logic_tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic flag_timing_select = 1'b1;
  logic want_write = 1'b0;
  logic want_read = 1'b0;
  logic write_clock_tick, write_enable, read_clock_tick, read_enable;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq;
  logic empty_flag_n, almost_empty_flag_n, half_full_flag_n, almost_full_flag_n, full_flag_n;
  int fail_count = 0;
  int total_checks = 0;
  int cnt, cap, depth, fw, n_off, m_off;
  logic sync_sel, af_on, ae_on;
  logic [31:0] rd;
  logic [2:0] modes [3] = '{3'h6, 3'h7, 3'h0};

  always #20 clk_sys = ~clk_sys;

  fifo_port_model port_model (
    .want_write(want_write),
    .want_read(want_read),
    .write_clock_tick(write_clock_tick),
    .write_enable(write_enable),
    .read_clock_tick(read_clock_tick),
    .read_enable(read_enable)
  );

  fifo_status_flags dut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .flag_timing_select(flag_timing_select),
    .write_clock_tick(write_clock_tick),
    .read_clock_tick(read_clock_tick),
    .write_enable(write_enable),
    .read_enable(read_enable),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .irq(irq),
    .empty_flag_n(empty_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n),
    .half_full_flag_n(half_full_flag_n),
    .almost_full_flag_n(almost_full_flag_n),
    .full_flag_n(full_flag_n)
  );

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    // Only the watchdog ends a wait that never sees waitrequest low
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Pin levels expected from the word count and the flag memories
  function automatic logic [4:0] exp_flags();
    return {(fw != 0) == (cnt == cap), !af_on, !(cnt > depth / 2 + fw), !ae_on, (fw != 0) == (cnt == 0)};
  endfunction

  task automatic op(input logic w, input logic r);
    logic wok, rok, af_met, ae_met;
    want_write <= w;
    want_read <= r;
    @(posedge clk_sys);
    want_write <= 1'b0;
    want_read <= 1'b0;
    wok = w && cnt < cap;
    rok = r && cnt > 0;
    cnt = cnt + int'(wok) - int'(rok);
    af_met = cnt >= depth + fw - m_off;
    ae_met = cnt <= n_off + fw;
    if (sync_sel) begin
      af_on = w ? af_met : af_on;
      ae_on = r ? ae_met : ae_on;
    end else begin
      af_on = (w && af_met) ? 1'b1 : ((r && !af_met) ? 1'b0 : af_on);
      ae_on = (r && ae_met) ? 1'b1 : ((w && !ae_met) ? 1'b0 : ae_on);
    end
    @(posedge clk_sys);
    #1;
    check("flags", {full_flag_n, almost_full_flag_n, half_full_flag_n, almost_empty_flag_n, empty_flag_n},
      exp_flags());
  endtask

  task automatic do_reset(input logic s);
    rstn <= 1'b0;
    flag_timing_select <= s;
    repeat (12) @(posedge clk_sys);
    check("held flags", {full_flag_n, almost_full_flag_n, half_full_flag_n, almost_empty_flag_n, empty_flag_n},
      5'b11100);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check("reset flags", {full_flag_n, almost_full_flag_n, half_full_flag_n, almost_empty_flag_n, empty_flag_n},
      5'b11100);
    // Strap moves after reset; the chosen timing must not follow it
    flag_timing_select <= ~s;
    sync_sel = s;
    cnt = 0;
    fw = 0;
    depth = 2048;
    cap = 2048;
    n_off = 127;
    m_off = 127;
    af_on = 1'b0;
    ae_on = 1'b1;
    bus(1'b0, fifo_flag_pkg::ADDR_FLAGS, 32'h0, rd);
    check("timing mode", rd[6:5], {1'b0, s});
    bus(1'b0, fifo_flag_pkg::ADDR_CTRL, 32'h0, rd);
    check("ctrl reset", rd, fifo_flag_pkg::CTRL_RESET);
    bus(1'b0, fifo_flag_pkg::ADDR_AE_OFFSET, 32'h0, rd);
    check("offset reset", rd, fifo_flag_pkg::OFFSET_RESET);
    bus(1'b0, 8'h1C, 32'h0, rd);
    check("unmapped", rd, 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(77));
    for (int s = 1; s >= 0; s--) begin
      do_reset(s[0]);
      bus(1'b1, fifo_flag_pkg::ADDR_AE_OFFSET, 32'h3, rd);
      bus(1'b1, fifo_flag_pkg::ADDR_AF_OFFSET, 32'h5, rd);
      n_off = 3;
      m_off = 5;
      // The both-x9 mode doubles the fill time, so it runs in one timing mode only
      for (int i = 0; i < (s == 1 ? 3 : 2); i++) begin
        bus(1'b1, fifo_flag_pkg::ADDR_CTRL, {29'h0, modes[i]}, rd);
        fw = int'(modes[i][0]);
        depth = (modes[i][2:1] == 2'b00) ? 4096 : 2048;
        cap = depth + fw;
        repeat (150) op(1'($urandom), 1'($urandom));
        while (cnt < cap) op(1'b1, 1'b0);
        op(1'b1, 1'b1);
        op(1'b1, 1'b0);
        op(1'b1, 1'b0);
        while (cnt > 0) op(1'b0, 1'b1);
        op(1'b0, 1'b1);
        bus(1'b0, fifo_flag_pkg::ADDR_INT_STATUS, 32'h0, rd);
        check("int status", rd, 32'h7F);
        bus(1'b1, fifo_flag_pkg::ADDR_INT_MASK, 32'h20, rd);
        bus(1'b0, fifo_flag_pkg::ADDR_INT_MASK, 32'h0, rd);
        check("irq set", irq, 32'h1);
        bus(1'b1, fifo_flag_pkg::ADDR_INT_STATUS, 32'h7F, rd);
        bus(1'b0, fifo_flag_pkg::ADDR_INT_STATUS, 32'h0, rd);
        check("status clear", rd, 32'h0);
        check("irq clear", irq, 32'h0);
        bus(1'b1, fifo_flag_pkg::ADDR_INT_MASK, 32'h0, rd);
      end
    end
    finish_test();
  end

  // Longest path is about 52000 cycles; stay under the run budget
  initial begin
    #(40 * 90000);
    fail_count++;
    finish_test();
  end
endmodule
